// [src/fep_rx_pcs.sv]
// Receive coding path: MLT-3 symbols in, MII nibbles out
`timescale 1ns/1ps
`default_nettype none
module fep_rx_pcs
  import fep_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = FEP_HOLD_CYC,
  parameter int unsigned LINK_CYCLES = FEP_LINK_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] line_lvl,
  input wire logic energy_in,
  input wire logic descr_bypass,
  output logic sig_det_q,
  output logic link_up_q,
  output logic lock_q,
  output logic rx_dv_q,
  output logic rx_er_q,
  output logic [NIB_W-1:0] rxd_q,
  output logic nib_stb_q,
  output logic crs_q,
  output logic bad_stream_start_q,
  output logic [FCC_W-1:0] false_carrier_event_counter_q
);

  logic [7:0] sd_cnt_q;
  logic [LINK_W-1:0] link_cnt_q;
  logic nrzi_q;
  logic nrz_q;
  logic [10:0] lfsr_q;
  logic [6:0] match_cnt_q;
  logic [HOLD_W-1:0] hold_q;
  logic [6:0] ls_run_q;
  logic ud_q;
  logic ud_ok_q;
  logic [9:0] sr_q;
  logic [6:0] run_q;
  logic [2:0] ph_q;
  logic [2:0] wait_q;
  logic sym_use_q;
  logic idle1_q;
  logic [NIB_W-1:0] pend_q;
  logic pend_err_q;
  fep_st_t st_q;
  fep_kind_t kind;
  logic [NIB_W-1:0] nib;

  // Signal detect: energy must persist longer than any link pulse
  wire sd_full = sd_cnt_q == 8'(SD_QUAL_CYC);
  always_ff @(posedge clk) begin
    if (srst || !energy_in) begin
      sd_cnt_q <= 8'h00;
      sig_det_q <= 1'b0;
    end else begin
      if (!sd_full) begin
        sd_cnt_q <= sd_cnt_q + 8'h01;
      end
      sig_det_q <= sd_full;
    end
  end

  // Link monitor needs unbroken signal detect
  wire link_full = link_cnt_q == LINK_W'(LINK_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (srst || !sig_det_q) begin
      link_cnt_q <= '0;
      link_up_q <= 1'b0;
    end else if (link_full) begin
      link_up_q <= 1'b1;
    end else begin
      link_cnt_q <= link_cnt_q + LINK_W'(1);
    end
  end

  // MLT-3 level to NRZI, then NRZI to NRZ
  wire nrzi_d = line_lvl != 2'b00;
  always_ff @(posedge clk) begin
    if (srst) begin
      nrzi_q <= 1'b0;
      nrz_q <= 1'b0;
    end else begin
      nrzi_q <= nrzi_d;
      nrz_q <= nrzi_d ^ nrzi_q;
    end
  end

  // Descrambler, x^11 + x^9 + 1
  wire key = lfsr_q[10] ^ lfsr_q[8];
  wire idle_guess = ~nrz_q;
  wire ud_d = nrz_q ^ key;
  wire ls_hit = ud_d && ls_run_q == LS_IDLE_BITS - 7'd1;
  wire hold_end = hold_q == '0;
  always_ff @(posedge clk) begin
    if (srst || (lock_q && hold_end)) begin
      lfsr_q <= LFSR_RST;
      match_cnt_q <= 7'd0;
      lock_q <= 1'b0;
      hold_q <= '0;
      ls_run_q <= 7'd0;
      ud_q <= 1'b0;
      ud_ok_q <= 1'b0;
    end else if (!lock_q) begin
      // While idle, the key equals the inverted line bit
      lfsr_q <= {lfsr_q[9:0], idle_guess};
      ud_ok_q <= 1'b0;
      if (idle_guess != key) begin
        match_cnt_q <= 7'd0;
      end else if (match_cnt_q == LOCK_BITS - 7'd1) begin
        lock_q <= 1'b1;
        hold_q <= HOLD_W'(HOLD_CYCLES - 1);
      end else begin
        match_cnt_q <= match_cnt_q + 7'd1;
      end
    end else begin
      lfsr_q <= {lfsr_q[9:0], key};
      ud_q <= ud_d;
      ud_ok_q <= 1'b1;
      ls_run_q <= (ud_d && !ls_hit) ? ls_run_q + 7'd1 : 7'd0;
      hold_q <= ls_hit ? HOLD_W'(HOLD_CYCLES - 1) : hold_q - HOLD_W'(1);
    end
  end

  // Aligner input: descrambled bits, or NRZ bits when bypassed
  wire s_bit = descr_bypass ? nrz_q : ud_q;
  wire s_ok = (descr_bypass || ud_ok_q) && link_up_q;
  wire sym_stb = s_ok && ph_q == SYM_LAST_PH && st_q inside {ST_PKT, ST_TAIL, ST_BAD};
  wire ssd_start = st_q == ST_IDLE && s_ok && !s_bit && run_q >= SSD_RUN_BITS;
  wire ssd_done = st_q == ST_SSD && s_ok && wait_q == SSD_WAIT_BITS;
  wire jk_seen = sr_q == {CG_J, CG_K};

  always_ff @(posedge clk) begin
    if (srst) begin
      sr_q <= SR_RST;
      run_q <= 7'd0;
      ph_q <= 3'd0;
      wait_q <= 3'd0;
      sym_use_q <= 1'b0;
    end else begin
      sym_use_q <= sym_stb;
      if (s_ok) begin
        sr_q <= {sr_q[8:0], s_bit};
        run_q <= !s_bit ? 7'd0 : (run_q == RUN_MAX ? run_q : run_q + 7'd1);
        wait_q <= ssd_start ? 3'd0 : wait_q + 3'd1;
        // Boundary fixed at the end of K
        ph_q <= (ssd_done || ph_q == SYM_LAST_PH) ? 3'd0 : ph_q + 3'd1;
      end
    end
  end

  fep_code_rom u_rom (
    .clk(clk),
    .addr(sr_q[4:0]),
    .kind_q(kind),
    .nib_q(nib)
  );

  // Receive state machine and MII outputs
  always_ff @(posedge clk) begin
    if (srst || !link_up_q) begin
      st_q <= ST_IDLE;
      rx_dv_q <= 1'b0;
      rx_er_q <= 1'b0;
      rxd_q <= NIB_ZERO;
      nib_stb_q <= 1'b0;
      crs_q <= 1'b0;
      bad_stream_start_q <= 1'b0;
      idle1_q <= 1'b0;
      pend_q <= NIB_ZERO;
      pend_err_q <= 1'b0;
      if (srst) begin
        false_carrier_event_counter_q <= '0;
      end
    end else begin
      nib_stb_q <= 1'b0;
      bad_stream_start_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (ssd_start) begin
            st_q <= ST_SSD;
            crs_q <= 1'b1;
          end
        end
        ST_SSD: begin
          if (ssd_done && jk_seen) begin
            // Output lags one symbol so K can become the second preamble nibble
            st_q <= ST_PKT;
            rx_dv_q <= 1'b1;
            rxd_q <= NIB_PRE;
            nib_stb_q <= 1'b1;
            pend_q <= NIB_PRE;
            pend_err_q <= 1'b0;
            idle1_q <= 1'b0;
          end else if (ssd_done) begin
            st_q <= ST_BAD;
            bad_stream_start_q <= 1'b1;
            rx_er_q <= 1'b1;
            rxd_q <= NIB_BAD;
            nib_stb_q <= 1'b1;
            idle1_q <= 1'b0;
            false_carrier_event_counter_q <= false_carrier_event_counter_q + FCC_W'(1);
          end
        end
        ST_PKT: begin
          if (sym_use_q) begin
            rxd_q <= pend_q;
            rx_er_q <= pend_err_q;
            nib_stb_q <= 1'b1;
            pend_q <= nib;
            pend_err_q <= kind != K_DATA;
            idle1_q <= kind == K_IDLE;
            if (kind == K_T) begin
              st_q <= ST_TAIL;
            end else if (kind == K_IDLE && idle1_q) begin
              st_q <= ST_IDLE;
              rx_dv_q <= 1'b0;
              rx_er_q <= 1'b0;
              crs_q <= 1'b0;
              nib_stb_q <= 1'b0;
            end
          end
        end
        ST_TAIL: begin
          // Last data nibble stands for the period of R
          if (sym_use_q) begin
            st_q <= ST_IDLE;
            rx_dv_q <= 1'b0;
            rx_er_q <= 1'b0;
            rxd_q <= NIB_ZERO;
            crs_q <= 1'b0;
          end
        end
        ST_BAD: begin
          if (sym_use_q) begin
            idle1_q <= kind == K_IDLE;
            if (kind == K_IDLE && idle1_q) begin
              st_q <= ST_IDLE;
              rx_er_q <= 1'b0;
              crs_q <= 1'b0;
              rxd_q <= NIB_ZERO;
            end else begin
              rx_er_q <= 1'b1;
              rxd_q <= NIB_BAD;
              nib_stb_q <= 1'b1;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  a_sd_no_pulse: assert property (@(posedge clk) disable iff (srst)
    $rose(sig_det_q) |-> $past(energy_in, 1) && $past(energy_in, 20))
    else $error("signal detect rose on short energy burst");

  a_nrz_xor: assert property (@(posedge clk) disable iff (srst)
    nrz_q == (nrzi_q ^ $past(nrzi_q)))
    else $error("NRZ bit is not the NRZI transition");

  a_lock_idles: assert property (@(posedge clk) disable iff (srst)
    $rose(lock_q) |-> $past(match_cnt_q) == LOCK_BITS - 7'd1)
    else $error("lock declared before sixty idle bits");

  a_hold_reload: assert property (@(posedge clk) disable iff (srst)
    lock_q && ls_hit && !hold_end |=> hold_q == HOLD_W'(HOLD_CYCLES - 1))
    else $error("hold timer not restarted on idle run");

  a_hold_expire: assert property (@(posedge clk) disable iff (srst)
    lock_q && hold_end |=> !lock_q && lfsr_q == LFSR_RST)
    else $error("descrambler kept lock after hold expiry");

  a_link_gate: assert property (@(posedge clk) disable iff (srst)
    !link_up_q |=> !rx_dv_q && !crs_q)
    else $error("receive active without link");

  a_bad_count: assert property (@(posedge clk) disable iff (srst)
    st_q == ST_SSD && ssd_done && !jk_seen && link_up_q |=>
    false_carrier_event_counter_q == $past(false_carrier_event_counter_q) + FCC_W'(1))
    else $error("false carrier counter not advanced by one");

  a_bad_nibble: assert property (@(posedge clk) disable iff (srst)
    st_q == ST_BAD && nib_stb_q |-> rx_er_q && rxd_q == NIB_BAD)
    else $error("bad start nibble not 1110 with error");

  a_preamble: assert property (@(posedge clk) disable iff (srst)
    $rose(rx_dv_q) |-> rxd_q == NIB_PRE ##6 (!link_up_q || rxd_q == NIB_PRE))
    else $error("preamble pair not 0101 0101");

  a_nib_pace: assert property (@(posedge clk) disable iff (srst)
    nib_stb_q |=> !nib_stb_q [*4])
    else $error("nibbles closer than one symbol period");

  a_tail_end: assert property (@(posedge clk) disable iff (srst)
    st_q == ST_TAIL && sym_use_q |=> st_q == ST_IDLE && !rx_dv_q && !crs_q)
    else $error("packet did not end after end delimiter pair");

  a_bad_exit: assert property (@(posedge clk) disable iff (srst)
    st_q == ST_BAD && sym_use_q && kind == K_IDLE && idle1_q |=>
    st_q == ST_IDLE && !rx_er_q && !crs_q)
    else $error("error or carrier kept after two idle groups");

  a_bad_flag: assert property (@(posedge clk) disable iff (srst)
    bad_stream_start_q |-> st_q == ST_BAD && rx_er_q && crs_q)
    else $error("bad start flagged outside the error state");

  a_link_wait: assert property (@(posedge clk) disable iff (srst)
    $rose(link_up_q) |-> $past(link_cnt_q) == LINK_W'(LINK_CYCLES - 1))
    else $error("link up before the full qualification time");

  a_ctl_error: assert property (@(posedge clk) disable iff (srst)
    link_up_q && st_q == ST_PKT && sym_use_q && kind != K_DATA |=>
    pend_err_q && pend_q == NIB_ZERO)
    else $error("control or invalid group decoded as data");

  a_bypass_feed: assert property (@(posedge clk) disable iff (srst)
    descr_bypass && link_up_q |=> sr_q[0] == $past(nrz_q))
    else $error("aligner not fed from the NRZ stage in bypass");

  a_descr_out: assert property (@(posedge clk) disable iff (srst)
    lock_q && !hold_end |=> ud_q == ($past(nrz_q) ^ $past(key)))
    else $error("descrambled bit is not line bit XOR key");

endmodule // fep_rx_pcs
`default_nettype wire

// [shared/fep_pkg.sv]
// Constants and types shared by the 100 Mb/s receive coding path
package fep_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int HOLD_TIME_US = 722;
  localparam int LINK_TIME_US = 395;
  localparam int SD_QUAL_NS = 200;
  localparam int FEP_HOLD_CYC = HOLD_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int FEP_LINK_CYC = (LINK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SD_QUAL_CYC = (SD_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Widths
  localparam int HOLD_W = 17;
  localparam int LINK_W = 16;
  localparam int SYM_W = 5;
  localparam int NIB_W = 4;
  localparam int FCC_W = 16;

  // Counts in bit times
  localparam logic [6:0] LOCK_BITS = 7'd60;
  localparam logic [6:0] LS_IDLE_BITS = 7'd58;
  localparam logic [6:0] SSD_RUN_BITS = 7'd12;
  localparam logic [2:0] SSD_WAIT_BITS = 3'd7;
  localparam logic [2:0] SYM_LAST_PH = 3'd4;
  localparam logic [6:0] RUN_MAX = 7'h7F;

  // Code groups
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_HALT = 5'h04;

  // Nibbles
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_BAD = 4'hE;
  localparam logic [3:0] NIB_ZERO = 4'h0;

  // Reset values
  localparam logic [10:0] LFSR_RST = 11'h000;
  localparam logic [9:0] SR_RST = 10'h000;

  typedef enum logic [2:0] {
    K_DATA, K_IDLE, K_J, K_K, K_T, K_R, K_HALT, K_INV
  } fep_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SSD, ST_PKT, ST_TAIL, ST_BAD
  } fep_st_t;

endpackage

// [src/fep_code_rom.sv]
// 5B to 4B code-group lookup table with registered output
`timescale 1ns/1ps
`default_nettype none
module fep_code_rom
  import fep_pkg::*;
(
  input wire logic clk,
  input wire logic [SYM_W-1:0] addr,
  output fep_kind_t kind_q,
  output logic [NIB_W-1:0] nib_q
);

  always_ff @(posedge clk) begin
    kind_q <= K_DATA;
    nib_q <= NIB_ZERO;
    case (addr)
      5'h1E: nib_q <= 4'h0;
      5'h09: nib_q <= 4'h1;
      5'h14: nib_q <= 4'h2;
      5'h15: nib_q <= 4'h3;
      5'h0A: nib_q <= 4'h4;
      5'h0B: nib_q <= 4'h5;
      5'h0E: nib_q <= 4'h6;
      5'h0F: nib_q <= 4'h7;
      5'h12: nib_q <= 4'h8;
      5'h13: nib_q <= 4'h9;
      5'h16: nib_q <= 4'hA;
      5'h17: nib_q <= 4'hB;
      5'h1A: nib_q <= 4'hC;
      5'h1B: nib_q <= 4'hD;
      5'h1C: nib_q <= 4'hE;
      5'h1D: nib_q <= 4'hF;
      CG_IDLE: kind_q <= K_IDLE;
      CG_J: kind_q <= K_J;
      CG_K: kind_q <= K_K;
      CG_T: kind_q <= K_T;
      CG_R: kind_q <= K_R;
      CG_HALT: kind_q <= K_HALT;
      default: kind_q <= K_INV;
    endcase
  end

endmodule // fep_code_rom
`default_nettype wire

// [bench/fep_line_tx.sv]
// Line-side transmitter model: scrambler, NRZI and MLT-3 toward the receiver
`timescale 1ns/1ps
`default_nettype none
module fep_line_tx (
  input wire logic clk,
  input wire logic scr_en,
  output logic [1:0] line_lvl
);
  // Arbitrary nonzero seed; the receiver must find it on its own
  logic [10:0] key = 11'h2A5;
  logic [1:0] ph = 2'd0;
  initial line_lvl = 2'b00;
  // Group MSB goes first; every one steps the MLT-3 level
  task automatic send_group(input logic [4:0] g);
    logic n;
    for (int i = 4; i >= 0; i--) begin
      n = key[10] ^ key[8];
      key = {key[9:0], n};
      ph = ph + {1'b0, g[i] ^ (scr_en & n)};
      @(posedge clk);
      line_lvl <= !ph[0] ? 2'b00 : (ph[1] ? 2'b11 : 2'b01);
    end
  endtask
endmodule // fep_line_tx
`default_nettype wire

// [bench/test_fep_rx_pcs.sv]
// Self-checking bench for the receive coding path
`timescale 1ns/1ps
`default_nettype none
module test_fep_rx_pcs import fep_pkg::*; ;
  localparam int unsigned LINK_C = 50;
  localparam logic [4:0] DATA_CG [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic clk, srst, energy_in, descr_bypass, scr_en;
  logic [1:0] line_lvl;
  logic sig_det_q, link_up_q, lock_q, rx_dv_q, rx_er_q, nib_stb_q, crs_q, bad_stream_start_q;
  logic [NIB_W-1:0] rxd_q;
  logic [FCC_W-1:0] false_carrier_event_counter_q;
  logic [5:0] got[$];
  int bad_count = 0;
  int comparisons = 0;
  int pulses = 0;

  fep_rx_pcs #(.HOLD_CYCLES(200), .LINK_CYCLES(LINK_C)) dut (.clk(clk), .srst(srst),
    .line_lvl(line_lvl), .energy_in(energy_in), .descr_bypass(descr_bypass),
    .sig_det_q(sig_det_q), .link_up_q(link_up_q), .lock_q(lock_q), .rx_dv_q(rx_dv_q),
    .rx_er_q(rx_er_q), .rxd_q(rxd_q), .nib_stb_q(nib_stb_q), .crs_q(crs_q),
    .bad_stream_start_q(bad_stream_start_q),
    .false_carrier_event_counter_q(false_carrier_event_counter_q));
  fep_line_tx tx (.clk(clk), .scr_en(scr_en), .line_lvl(line_lvl));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Registered outputs read at the edge give their pre-edge values
  always @(posedge clk) begin
    if (nib_stb_q === 1'b1) got.push_back({rx_dv_q, rx_er_q, rxd_q});
    if (bad_stream_start_q === 1'b1) pulses++;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic send(input logic [4:0] gs[$]);
    foreach (gs[i]) tx.send_group(gs[i]);
  endtask

  task automatic check_nibs(input logic [5:0] ex[$]);
    check("nibble count", 16'(ex.size()), 16'(got.size()));
    foreach (ex[i]) if (i < got.size()) check("nibble", 16'(ex[i]), 16'(got[i]));
  endtask

  task automatic t_link;
    int n;
    energy_in <= 1'b1;
    repeat (20) @(posedge clk);
    energy_in <= 1'b0;
    repeat (5) @(posedge clk);
    check("sig_det after burst", 16'h0, 16'(sig_det_q));
    energy_in <= 1'b1;
    n = 0;
    while (link_up_q !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n == 500) begin
      bad_count++;
      give_verdict;
    end
    check("link delay", 16'h1, 16'(n >= SD_QUAL_CYC + LINK_C && n <= SD_QUAL_CYC + LINK_C + 8));
    check("sig_det", 16'h1, 16'(sig_det_q));
    $display("test link done");
  endtask

  // Every data code in one packet, descrambler bypassed
  task automatic t_good;
    logic [4:0] gs[$];
    logic [5:0] ex[$];
    got.delete();
    gs = '{CG_IDLE, CG_IDLE, CG_IDLE, CG_IDLE, CG_J, CG_K};
    ex = '{6'h25, 6'h25};
    for (int i = 0; i < 16; i++) begin
      gs.push_back(DATA_CG[i]);
      ex.push_back({2'b10, 4'(i)});
    end
    gs = {gs, CG_T, CG_R, CG_IDLE, CG_IDLE, CG_IDLE, CG_IDLE};
    send(gs);
    check_nibs(ex);
    check("dv crs after end", 16'h0, 16'({rx_dv_q, crs_q}));
    $display("test good packet done");
  endtask

  task automatic t_ctl;
    got.delete();
    send('{CG_IDLE, CG_IDLE, CG_IDLE, CG_IDLE, CG_J, CG_K, 5'h09, CG_HALT, 5'h00, CG_J, CG_R,
      5'h09, CG_T, CG_R, CG_IDLE, CG_IDLE, CG_IDLE, CG_IDLE, CG_J, CG_K, 5'h14, CG_IDLE,
      CG_IDLE, CG_IDLE, CG_IDLE});
    check_nibs('{6'h25, 6'h25, 6'h21, 6'h30, 6'h30, 6'h30, 6'h30, 6'h21, 6'h25, 6'h25,
      6'h22});
    check("dv crs er after idles", 16'h0, 16'({rx_dv_q, crs_q, rx_er_q}));
    $display("test control in data done");
  endtask

  task automatic t_bad;
    logic [FCC_W-1:0] c0;
    int p0;
    c0 = false_carrier_event_counter_q;
    p0 = pulses;
    got.delete();
    send('{CG_IDLE, CG_IDLE, CG_IDLE, CG_IDLE, 5'h0A, 5'h0B, 5'h0E, CG_IDLE, CG_IDLE, CG_IDLE,
      CG_IDLE});
    check("false carrier count", c0 + 16'h0001, false_carrier_event_counter_q);
    check("bad start pulses", 16'h1, 16'(pulses - p0));
    check("bad nibbles", 16'h1, 16'(got.size() >= 2));
    for (int i = 0; i < 2 && i < got.size(); i++) check("bad nibble", 16'h1E, 16'(got[i][4:0]));
    check("er crs after idles", 16'h0, 16'({rx_er_q, crs_q}));
    $display("test bad start done");
  endtask

  // Scrambled line: lock, decode, hold restart, then expiry on idle-free data
  task automatic t_lock;
    descr_bypass <= 1'b0;
    scr_en <= 1'b1;
    // Key needs eleven loaded bits before sixty can match
    repeat (16) tx.send_group(CG_IDLE);
    check("lock", 16'h1, 16'(lock_q));
    got.delete();
    send('{CG_J, CG_K, 5'h09, CG_T, CG_R, CG_IDLE, CG_IDLE, CG_IDLE, CG_IDLE});
    check_nibs('{6'h25, 6'h25, 6'h21});
    repeat (40) tx.send_group(CG_IDLE);
    check("lock held", 16'h1, 16'(lock_q));
    repeat (50) tx.send_group(5'h0A);
    check("lock dropped", 16'h0, 16'(lock_q));
    $display("test descrambler lock done");
  endtask

  initial begin
    srst = 1'b1;
    energy_in = 1'b0;
    descr_bypass = 1'b1;
    scr_en = 1'b0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_link;
    t_good;
    t_ctl;
    t_bad;
    t_lock;
    give_verdict;
  end
endmodule // test_fep_rx_pcs
`default_nettype wire
